// *** verilog/dstsy_core.sv ***
`timescale 1ns/10ps
`default_nettype none

module dstsy_core (
    input wire logic clk_i, // System clock, 100 MHz.
    input wire logic rstn_i, // Asynchronous reset, active low.
    input wire dstsy_pkg::dstsy_time_t time_i, // Current time from the clock.
    input wire logic operating_i, // High in run or stop, low when buffered.
    input wire logic cfg_we_i, // Pulse: store cfg_wdata_i.
    input wire dstsy_pkg::dstsy_cfg_t cfg_wdata_i, // New settings.
    output dstsy_pkg::dstsy_cfg_t cfg_o, // Held settings, readable.
    input wire logic set_i, // Pulse: explicit clock set request.
    input wire dstsy_pkg::dstsy_time_t set_time_i, // Time for the explicit set.
    input wire logic sync_valid_i, // Pulse: time offered by comm module.
    input wire dstsy_pkg::dstsy_time_t sync_time_i, // Time from comm module.
    output logic load_o, // Pulse: load load_time_o into the clock.
    output dstsy_pkg::dstsy_time_t load_time_o, // Time to load.
    output logic tx_valid_o, // Time offered to expansion modules.
    input wire logic tx_ready_i, // Expansion side accepts the time.
    output dstsy_pkg::dstsy_time_t tx_time_o, // Time sent to expansion modules.
    output logic summer_o, // High while summertime is active.
    output logic busy_o // High while a load or send is in progress.
);
    import dstsy_pkg::*;

    typedef enum logic [1:0] {
        DSTSY_IDLE = 2'b00,
        DSTSY_LOAD = 2'b01,
        DSTSY_SEND = 2'b11
    } dstsy_state_t;

    dstsy_state_t state;
    dstsy_state_t next_state;
    dstsy_cfg_t cfg;
    dstsy_cfg_t next_cfg;
    dstsy_time_t load_time;
    dstsy_time_t next_load_time;
    dstsy_time_t tx_time;
    dstsy_time_t next_tx_time;
    logic load;
    logic next_load;
    logic summer;
    logic next_summer;
    logic send_after;
    logic next_send_after;
    logic send_pend;
    logic next_send_pend;
    logic [4:0] last_hour;
    logic [4:0] next_last_hour;
    logic hour_tick;
    logic dst_ok;
    dstsy_shift_t shift;

    // Rule lookup and date matching for the selected rule set.
    dstsy_rule_match u_match (
        .now_i(time_i),
        .cfg_i(cfg),
        .shift_o(shift)
    );

    // Conversion runs only when enabled and powered from the supply.
    assign dst_ok = cfg.dst_en && operating_i;

    // A change of hour on the clock marks the hourly broadcast.
    assign hour_tick = (time_i.hour != last_hour);

    // Settings are stored as written; reset leaves them all off.
    always_comb begin
        next_cfg = cfg;
        if (cfg_we_i) begin
            next_cfg = cfg_wdata_i;
        end
    end

    // Pending broadcast: set by power-up and hour change, set wins over clear.
    always_comb begin
        next_last_hour = time_i.hour;
        next_send_pend = send_pend;
        // A finished plain broadcast clears the request.
        if (state == DSTSY_SEND && tx_ready_i && !send_after) begin
            next_send_pend = 1'b0;
        end
        // Any change of hour asks for one more, even in the clearing cycle.
        if (hour_tick) begin
            next_send_pend = 1'b1;
        end
    end

    // Main sequencer: pick one clock change or one broadcast per pass.
    always_comb begin
        next_state = state;
        next_load = 1'b0;
        next_load_time = load_time;
        next_tx_time = tx_time;
        next_summer = summer;
        next_send_after = send_after;
        case (state)
            DSTSY_IDLE: begin
                if (cfg.time_sync_enable && sync_valid_i) begin
                    next_load = 1'b1;
                    next_load_time = sync_time_i;
                    next_send_after = 1'b0;
                    next_state = DSTSY_LOAD;
                end else if (set_i) begin
                    next_load = 1'b1;
                    next_load_time = set_time_i;
                    next_send_after = 1'b1;
                    next_state = DSTSY_LOAD;
                end else if (dst_ok && !summer && shift.fwd_hit) begin
                    next_load = 1'b1;
                    next_load_time = shift.fwd_time;
                    next_summer = 1'b1;
                    next_send_after = 1'b1;
                    next_state = DSTSY_LOAD;
                end else if (dst_ok && summer && shift.back_hit) begin
                    next_load = 1'b1;
                    next_load_time = shift.back_time;
                    next_summer = 1'b0;
                    next_send_after = 1'b1;
                    next_state = DSTSY_LOAD;
                end else if (send_pend) begin
                    next_tx_time = time_i;
                    next_send_after = 1'b0;
                    next_state = DSTSY_SEND;
                end
            end
            DSTSY_LOAD: begin
                // The new time goes out to the expansion modules after a set or a summertime switch, not after a sync load.
                if (send_after) begin
                    next_tx_time = load_time;
                    next_state = DSTSY_SEND;
                end else begin
                    next_state = DSTSY_IDLE;
                end
            end
            DSTSY_SEND: begin
                if (tx_ready_i) begin
                    next_send_after = 1'b0;
                    next_state = DSTSY_IDLE;
                end
            end
            default: begin
                next_state = DSTSY_IDLE;
            end
        endcase
        // Turning conversion off forgets summertime state.
        if (!cfg.dst_en) begin
            next_summer = 1'b0;
        end
    end

    // Settings register; reset leaves conversion and sync both disabled.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cfg <= DSTSY_CFG_RESET;
        end else begin
            cfg <= next_cfg;
        end
    end

    // Broadcast request; send_pend starts set so the first broadcast is the power-up one.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            send_pend <= 1'b1;
            last_hour <= '0;
        end else begin
            send_pend <= next_send_pend;
            last_hour <= next_last_hour;
        end
    end

    // Sequencer registers: state, load request, broadcast time and summer flag.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state <= DSTSY_IDLE;
            load <= 1'b0;
            load_time <= '0;
            tx_time <= '0;
            summer <= 1'b0;
            send_after <= 1'b0;
        end else begin
            state <= next_state;
            load <= next_load;
            load_time <= next_load_time;
            tx_time <= next_tx_time;
            summer <= next_summer;
            send_after <= next_send_after;
        end
    end

    // Settings read-back.
    assign cfg_o = cfg;

    // Clock load request, a one-cycle pulse with its time held until the next load.
    assign load_o = load;
    assign load_time_o = load_time;

    // Broadcast handshake; valid stands until the expansion side accepts.
    assign tx_valid_o = (state == DSTSY_SEND);
    assign tx_time_o = tx_time;

    // Status.
    assign summer_o = summer;
    assign busy_o = (state != DSTSY_IDLE);

endmodule // dstsy_core

`default_nettype wire

// *** include/dstsy_pkg.sv ***
package dstsy_pkg;

    // Local time as the real-time clock presents it; wday 0 is Sunday.
    typedef struct packed {
        logic [5:0] sec;
        logic [5:0] min;
        logic [4:0] hour;
        logic [4:0] day;
        logic [3:0] month;
        logic [2:0] wday;
    } dstsy_time_t;

    // Conversion rule sets; the last one takes its dates from the user fields.
    typedef enum logic [2:0] {
        DSTSY_PRESET_BRUSSELS_RULE = 3'h0,
        DSTSY_PRESET_BRITAIN = 3'h1,
        DSTSY_PRESET_AMERICA_OLD = 3'h2,
        DSTSY_PRESET_AMERICA_NEW = 3'h3,
        DSTSY_PRESET_DOWN_UNDER_MAINLAND = 3'h4,
        DSTSY_PRESET_ISLAND_STATE_SOUTH = 3'h5,
        DSTSY_PRESET_KIWI = 3'h6,
        DSTSY_USER_DEFINED = 3'h7
    } dstsy_rule_t;

    // Which Sunday of a month a preset switches on; DSTSY_ORD_DATE takes the user day instead.
    typedef enum logic [2:0] {
        DSTSY_ORD_FIRST = 3'h0,
        DSTSY_ORD_SECOND = 3'h1,
        DSTSY_ORD_THIRD = 3'h2,
        DSTSY_ORD_LAST = 3'h3,
        DSTSY_ORD_DATE = 3'h4
    } dstsy_ord_t;

    // Settings held by the block; all zero after reset means everything off.
    typedef struct packed {
        logic dst_en;
        dstsy_rule_t rule;
        logic time_sync_enable;
        logic [3:0] start_month;
        logic [4:0] start_day;
        logic [3:0] end_month;
        logic [4:0] end_day;
        logic [7:0] offset;
    } dstsy_cfg_t;

    // Results of matching the current time against the selected rule.
    typedef struct packed {
        logic fwd_hit;
        logic back_hit;
        dstsy_time_t fwd_time;
        dstsy_time_t back_time;
    } dstsy_shift_t;

    localparam dstsy_cfg_t DSTSY_CFG_RESET = '0;
    localparam logic [3:0] DSTSY_MARCH = 4'h3;
    localparam logic [3:0] DSTSY_APRIL = 4'h4;
    localparam logic [3:0] DSTSY_OCTOBER = 4'hA;
    localparam logic [3:0] DSTSY_NOVEMBER = 4'hB;
    localparam logic [2:0] DSTSY_SUNDAY = 3'h0;
    localparam logic [4:0] DSTSY_SECOND_LO = 5'h08;
    localparam logic [4:0] DSTSY_THIRD_LO = 5'h0F;
    localparam logic [4:0] DSTSY_LAST_LO = 5'h19;
    localparam logic [4:0] DSTSY_WEEK_SPAN = 5'h07;
    localparam logic [10:0] DSTSY_MOD_0100 = 11'h03C;
    localparam logic [10:0] DSTSY_MOD_0200 = 11'h078;
    localparam logic [10:0] DSTSY_MOD_0300 = 11'h0B4;
    localparam logic [10:0] DSTSY_MIN_PER_HOUR = 11'h03C;
    localparam logic [7:0] DSTSY_OFFSET_PRESET = 8'h3C;
    localparam logic [7:0] DSTSY_OFFSET_MAX = 8'hB4;

    // Minutes since midnight of a time value.
    function automatic logic [10:0] dstsy_mod(input dstsy_time_t t);
        dstsy_mod = 11'(t.hour * DSTSY_MIN_PER_HOUR) + 11'(t.min);
    endfunction

    // Replaces hour and minute of a time with a minutes-since-midnight value.
    function automatic dstsy_time_t dstsy_set_mod(input dstsy_time_t t, input logic [10:0] m);
        dstsy_time_t r;
        r = t;
        r.hour = 5'(m / DSTSY_MIN_PER_HOUR);
        r.min = 6'(m % DSTSY_MIN_PER_HOUR);
        r.sec = '0;
        dstsy_set_mod = r;
    endfunction

endpackage

// *** verilog/dstsy_rule_match.sv ***
`timescale 1ns/10ps
`default_nettype none

module dstsy_rule_match (
    input wire dstsy_pkg::dstsy_time_t now_i, // Current local time.
    input wire dstsy_pkg::dstsy_cfg_t cfg_i, // Held settings.
    output dstsy_pkg::dstsy_shift_t shift_o // Shift hits and target times.
);
    import dstsy_pkg::*;

    // True when the date falls on the chosen Sunday of the month, or on the user day for DSTSY_ORD_DATE.
    function automatic logic on_day(input dstsy_time_t t, input logic [3:0] mon,
                                    input dstsy_ord_t ord, input logic [4:0] uday);
        logic sun;
        logic hit;
        sun = (t.wday == DSTSY_SUNDAY);
        hit = 1'b0;
        case (ord)
            DSTSY_ORD_FIRST: hit = sun && (t.day < DSTSY_SECOND_LO);
            DSTSY_ORD_SECOND: hit = sun && (t.day >= DSTSY_SECOND_LO) &&
                                    (t.day < DSTSY_SECOND_LO + DSTSY_WEEK_SPAN);
            DSTSY_ORD_THIRD: hit = sun && (t.day >= DSTSY_THIRD_LO) &&
                                   (t.day < DSTSY_THIRD_LO + DSTSY_WEEK_SPAN);
            DSTSY_ORD_LAST: hit = sun && (t.day >= DSTSY_LAST_LO);
            default: hit = (t.day == uday);
        endcase
        on_day = hit && (t.month == mon);
    endfunction

    logic [3:0] s_mon;
    logic [3:0] e_mon;
    dstsy_ord_t s_ord;
    dstsy_ord_t e_ord;
    logic [10:0] s_mod;
    logic [10:0] e_mod;
    logic [7:0] ofs;
    logic [10:0] now_mod;

    // Rule table: dates, switch times and offset of each rule set.
    always_comb begin
        s_mon = DSTSY_MARCH;
        e_mon = DSTSY_OCTOBER;
        s_ord = DSTSY_ORD_LAST;
        e_ord = DSTSY_ORD_LAST;
        s_mod = DSTSY_MOD_0200;
        e_mod = DSTSY_MOD_0300;
        ofs = DSTSY_OFFSET_PRESET;
        case (cfg_i.rule)
            DSTSY_PRESET_BRUSSELS_RULE: begin
                s_mon = DSTSY_MARCH;
            end
            DSTSY_PRESET_BRITAIN: begin
                s_mod = DSTSY_MOD_0100;
                e_mod = DSTSY_MOD_0200;
            end
            DSTSY_PRESET_AMERICA_OLD: begin
                s_mon = DSTSY_APRIL;
                s_ord = DSTSY_ORD_FIRST;
                e_mod = DSTSY_MOD_0200;
            end
            DSTSY_PRESET_AMERICA_NEW: begin
                s_ord = DSTSY_ORD_SECOND;
                e_mon = DSTSY_NOVEMBER;
                e_ord = DSTSY_ORD_FIRST;
                e_mod = DSTSY_MOD_0200;
            end
            DSTSY_PRESET_DOWN_UNDER_MAINLAND: begin
                s_mon = DSTSY_OCTOBER;
                e_mon = DSTSY_MARCH;
            end
            DSTSY_PRESET_ISLAND_STATE_SOUTH: begin
                s_mon = DSTSY_OCTOBER;
                s_ord = DSTSY_ORD_FIRST;
                e_mon = DSTSY_MARCH;
            end
            DSTSY_PRESET_KIWI: begin
                s_mon = DSTSY_OCTOBER;
                s_ord = DSTSY_ORD_FIRST;
                e_mon = DSTSY_MARCH;
                e_ord = DSTSY_ORD_THIRD;
            end
            default: begin
                s_mon = cfg_i.start_month;
                e_mon = cfg_i.end_month;
                s_ord = DSTSY_ORD_DATE;
                e_ord = DSTSY_ORD_DATE;
                // Offsets above the allowed span are held at the maximum.
                ofs = (cfg_i.offset > DSTSY_OFFSET_MAX) ? DSTSY_OFFSET_MAX : cfg_i.offset;
            end
        endcase
    end

    // Hits fire only in the first second of the switch minute.
    assign now_mod = dstsy_mod(now_i);
    assign shift_o.fwd_hit = (now_i.sec == '0) && (now_mod == s_mod) &&
                             on_day(now_i, s_mon, s_ord, cfg_i.start_day);
    assign shift_o.back_hit = (now_i.sec == '0) && (now_mod == e_mod) &&
                              on_day(now_i, e_mon, e_ord, cfg_i.end_day);
    assign shift_o.fwd_time = dstsy_set_mod(now_i, 11'(s_mod + 11'(ofs)));
    assign shift_o.back_time = dstsy_set_mod(now_i, 11'(e_mod - 11'(ofs)));

endmodule // dstsy_rule_match

`default_nettype wire

// *** tb/dstsy_exp_model.sv ***
`timescale 1ns/10ps
`default_nettype none

// Expansion module side: takes broadcast times with random stalls.
module dstsy_exp_model (
    input wire logic clk_i, // Clock.
    input wire logic rstn_i, // Reset, active low.
    input wire logic tx_valid_i, // Time offered.
    input wire dstsy_pkg::dstsy_time_t tx_time_i, // Offered time.
    output logic tx_ready_o, // Accepts the time.
    output dstsy_pkg::dstsy_time_t last_o // Last accepted time.
);
    import dstsy_pkg::*;

    // Ready moves at the falling edge and stalls about one cycle in three.
    always @(negedge clk_i) begin
        tx_ready_o <= ($urandom_range(0, 2) != 0);
    end

    // Keeps the time taken where valid and ready meet.
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            last_o <= '0;
        end else if (tx_valid_i && tx_ready_o) begin
            last_o <= tx_time_i;
        end
    end
endmodule // dstsy_exp_model

`default_nettype wire

// *** tb/dstsy_core_asserts.sv ***
`timescale 1ns/10ps
`default_nettype none

// Watches the core ports at the rising clock edge.
module dstsy_core_asserts (
    input wire logic clk_i, // Clock.
    input wire logic rstn_i, // Reset.
    input wire dstsy_pkg::dstsy_time_t time_i, // Time.
    input wire logic operating_i, // Run or stop.
    input wire logic cfg_we_i, // Write.
    input wire dstsy_pkg::dstsy_cfg_t cfg_wdata_i, // New settings.
    input wire dstsy_pkg::dstsy_cfg_t cfg_o, // Settings.
    input wire logic set_i, // Set.
    input wire dstsy_pkg::dstsy_time_t set_time_i, // Set time.
    input wire logic sync_valid_i, // Sync.
    input wire dstsy_pkg::dstsy_time_t sync_time_i, // Sync time.
    input wire logic load_o, // Load.
    input wire dstsy_pkg::dstsy_time_t load_time_o, // Load time.
    input wire logic tx_valid_o, // Send valid.
    input wire logic tx_ready_i, // Send ready.
    input wire dstsy_pkg::dstsy_time_t tx_time_o, // Sent time.
    input wire logic summer_o, // Summer.
    input wire logic busy_o // Busy.
);
    import dstsy_pkg::*;
    logic sync_req;

    // A sync offer counts only while the held setting allows it.
    assign sync_req = sync_valid_i && cfg_o.time_sync_enable;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    cfg_write_a: assert property (cfg_we_i |=> cfg_o == $past(cfg_wdata_i))
        else $error("settings not stored");
    set_load_a: assert property (set_i && !busy_o && !sync_req |=>
        load_o && load_time_o == $past(set_time_i)) else $error("set not loaded");
    sync_load_a: assert property (sync_req && !busy_o |=>
        load_o && load_time_o == $past(sync_time_i)) else $error("sync not loaded");
    quiet_off_a: assert property (!cfg_o.dst_en && !set_i && !sync_req |=> !load_o)
        else $error("load while conversion off");
    quiet_buffered_a: assert property (!operating_i && !set_i && !sync_req |=> !load_o)
        else $error("load while buffered");
    tx_hold_a: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_time_o))
        else $error("send dropped before accept");
    summer_rise_a: assert property ($rose(summer_o) |-> load_o && load_time_o.sec == 6'h00)
        else $error("summer set without load");
    summer_fall_a: assert property ($fell(summer_o) && cfg_o.dst_en |-> load_o)
        else $error("summer cleared without load");
    user_clamp_a: assert property ($rose(summer_o) && cfg_o.rule == DSTSY_USER_DEFINED
        |-> load_time_o.hour <= 5'h05) else $error("offset above limit");
    load_pulse_a: assert property (load_o |=> !load_o)
        else $error("load longer than one cycle");
endmodule // dstsy_core_asserts

bind dstsy_core dstsy_core_asserts u_chk (.clk_i(clk_i), .rstn_i(rstn_i), .time_i(time_i),
    .operating_i(operating_i), .cfg_we_i(cfg_we_i), .cfg_wdata_i(cfg_wdata_i), .cfg_o(cfg_o),
    .set_i(set_i), .set_time_i(set_time_i), .sync_valid_i(sync_valid_i),
    .sync_time_i(sync_time_i), .load_o(load_o), .load_time_o(load_time_o),
    .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i), .tx_time_o(tx_time_o),
    .summer_o(summer_o), .busy_o(busy_o));

`default_nettype wire

// *** tb/testbench.sv ***
`timescale 1ns/10ps
`default_nettype none

// Drives the core at the falling edge and checks loads and broadcasts.
module testbench;
    import dstsy_pkg::*;
    logic clk_i, rstn_i, operating_i, cfg_we_i, set_i, sync_valid_i, load_o;
    logic tx_valid_o, tx_ready_i, summer_o, busy_o;
    dstsy_time_t time_i, set_time_i, sync_time_i, load_time_o, tx_time_o, last_tx;
    dstsy_cfg_t cfg_wdata_i, cfg_o, c;
    int failures, samples_checked, i, d, off;
    // Per preset: forward month, first day, minutes, back month, first day, minutes.
    int tbl [7][6] = '{'{3, 25, 120, 10, 25, 180}, '{3, 25, 60, 10, 25, 120},
        '{4, 1, 120, 10, 25, 120}, '{3, 8, 120, 11, 1, 120}, '{10, 25, 120, 3, 25, 180},
        '{10, 1, 120, 3, 25, 180}, '{10, 1, 120, 3, 15, 180}};

    // Free-running clock.
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    dstsy_core dut (.clk_i(clk_i), .rstn_i(rstn_i), .time_i(time_i),
        .operating_i(operating_i), .cfg_we_i(cfg_we_i), .cfg_wdata_i(cfg_wdata_i),
        .cfg_o(cfg_o), .set_i(set_i), .set_time_i(set_time_i), .sync_valid_i(sync_valid_i),
        .sync_time_i(sync_time_i), .load_o(load_o), .load_time_o(load_time_o),
        .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i), .tx_time_o(tx_time_o),
        .summer_o(summer_o), .busy_o(busy_o));

    dstsy_exp_model u_exp (.clk_i(clk_i), .rstn_i(rstn_i), .tx_valid_i(tx_valid_o),
        .tx_time_i(tx_time_o), .tx_ready_o(tx_ready_i), .last_o(last_tx));

    // Builds a Sunday time at second zero from month, day and minutes of day.
    function automatic dstsy_time_t mk(input int mo, input int dy, input int m);
        mk = '0;
        mk.month = 4'(mo);
        mk.day = 5'(dy);
        mk.hour = 5'(m / 60);
        mk.min = 6'(m % 60);
    endfunction

    // Compares and counts.
    task automatic check(input logic [34:0] seen, input logic [34:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic tally_and_finish;
        $display("checked %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // Waits until the core has been idle for four cycles.
    task automatic settle;
        int n, q;
        q = 0;
        for (n = 0; n < 400 && q < 4; n++) begin
            @(negedge clk_i);
            q = busy_o ? 0 : q + 1;
        end
        if (q < 4) begin
            failures++;
            tally_and_finish();
        end
    endtask

    // Drops request strobes, waits for a load and lets the clock show it.
    task automatic expect_load(input logic want, input dstsy_time_t exp);
        int n;
        logic got;
        got = 1'b0;
        for (n = 0; n < 100 && !got; n++) begin
            @(negedge clk_i);
            set_i = 1'b0;
            sync_valid_i = 1'b0;
            got = (load_o === 1'b1);
        end
        check(got, want);
        if (want && !got) tally_and_finish();
        if (got) check(load_time_o, exp);
        if (got) time_i = load_time_o;
        settle();
    endtask

    // Writes the settings and reads them back.
    task automatic wr(input dstsy_cfg_t v);
        @(negedge clk_i);
        cfg_we_i = 1'b1;
        cfg_wdata_i = v;
        @(negedge clk_i);
        cfg_we_i = 1'b0;
        check(cfg_o, v);
    endtask

    // Main sequence.
    initial begin
        void'($urandom(32'hdd4c));
        {failures, samples_checked} = '0;
        {rstn_i, cfg_we_i, set_i, sync_valid_i} = '0;
        operating_i = 1'b1;
        {cfg_wdata_i, set_time_i, sync_time_i} = '0;
        time_i = mk(1, 5, 630);
        repeat (4) @(negedge clk_i);
        check(cfg_o, DSTSY_CFG_RESET);
        rstn_i = 1'b1;
        settle();
        check(last_tx, time_i);
        time_i = mk(3, 25, 120);
        expect_load(1'b0, '0);
        // Every preset, forward then back, then the repeated hour.
        for (i = 0; i < 7; i++) begin
            c = '0;
            c.dst_en = 1'b1;
            c.rule = dstsy_rule_t'(i);
            wr(c);
            d = tbl[i][1] + $urandom_range(0, 6);
            time_i = mk(tbl[i][0], d, tbl[i][2]);
            expect_load(1'b1, mk(tbl[i][0], d, tbl[i][2] + 60));
            check(last_tx, time_i);
            check(summer_o, 1'b1);
            d = tbl[i][4] + $urandom_range(0, 6);
            time_i = mk(tbl[i][3], d, tbl[i][5]);
            expect_load(1'b1, mk(tbl[i][3], d, tbl[i][5] - 60));
            time_i = mk(tbl[i][3], d, tbl[i][5]);
            expect_load(1'b0, '0);
        end
        // User dates with the largest, an oversized and a random offset.
        for (i = 0; i < 3; i++) begin
            off = (i == 0) ? 180 : (i == 1) ? 200 : $urandom_range(0, 180);
            d = $urandom_range(1, 28);
            c = '0;
            c.dst_en = 1'b1;
            c.rule = DSTSY_USER_DEFINED;
            {c.start_month, c.end_month} = {4'h5, 4'h9};
            {c.start_day, c.end_day} = {5'(d), 5'(d)};
            c.offset = 8'(off);
            wr(c);
            if (off > 180) off = 180;
            operating_i = 1'b0;
            time_i = mk(5, d, 120);
            expect_load(1'b0, '0);
            operating_i = 1'b1;
            expect_load(1'b1, mk(5, d, 120 + off));
            time_i = mk(9, d, 180);
            expect_load(1'b1, mk(9, d, 180 - off));
        end
        sync_time_i = mk(7, 4, 900);
        sync_valid_i = 1'b1;
        expect_load(1'b0, '0);
        // A communication module stands beside the expansion side here.
        c.time_sync_enable = 1'b1;
        wr(c);
        sync_valid_i = 1'b1;
        expect_load(1'b1, sync_time_i);
        // Set times stay before 16:00 so the final hour change below is a real one.
        set_time_i = mk(6, 10, $urandom_range(0, 959));
        set_i = 1'b1;
        expect_load(1'b1, set_time_i);
        check(last_tx, set_time_i);
        time_i = mk(8, 8, 1000);
        settle();
        check(last_tx, time_i);
        tally_and_finish();
    end
endmodule // testbench

`default_nettype wire
